// ---- hw/efb_pkg.sv ----
// constants, register map and types of the earth fault block/trip stage
// assumes a 10 MHz clock and a 32-bit apb register bus
package efb_pkg;

  localparam int CLK_HZ     = 10_000_000;
  localparam int CYCLE_US   = 5000;
  localparam int CYCLE_CLKS = (CLK_HZ / 1_000_000) * CYCLE_US;
  localparam int MS_US      = 1000;
  localparam int MS_CLKS    = (CLK_HZ / 1_000_000) * MS_US;
  localparam int BLOCK_LEAD_US = 5000;

  localparam int REC_DEPTH = 12;
  localparam int CUR_W     = 16;
  localparam int GRP_W     = 3;
  localparam int STAMP_W   = 32;
  localparam int REC_W     = STAMP_W + 2 + GRP_W + 8 * CUR_W;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_EVT_CFG  = 8'h04;
  localparam logic [7:0] OFS_OP_DLY   = 8'h08;
  localparam logic [7:0] OFS_REL_DLY  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_TRIP_CNT = 8'h1C;
  localparam logic [7:0] OFS_BLK_CNT  = 8'h20;
  localparam logic [7:0] OFS_TIME     = 8'h24;
  localparam logic [7:0] OFS_REC_SEL  = 8'h28;
  localparam logic [7:0] OFS_REC_CNT  = 8'h2C;
  localparam logic [7:0] OFS_REC0     = 8'h30;
  localparam logic [7:0] OFS_REC1     = 8'h34;
  localparam logic [7:0] OFS_REC2     = 8'h38;
  localparam logic [7:0] OFS_REC3     = 8'h3C;
  localparam logic [7:0] OFS_REC4     = 8'h40;
  localparam logic [7:0] OFS_REC5     = 8'h44;

  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_CLR_BIT = 1;

  localparam logic        CTRL_EN_RST  = 1'h1;
  localparam logic [3:0]  EVT_CFG_RST  = 4'hF;
  localparam logic [15:0] OP_DLY_RST   = 16'h000A;
  localparam logic [15:0] REL_DLY_RST  = 16'h0004;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // event codes double as bit index in cfg, irq and pending vectors
  localparam logic [1:0] EV_TRIP_ON  = 2'h0;
  localparam logic [1:0] EV_TRIP_OFF = 2'h1;
  localparam logic [1:0] EV_BLK_ON   = 2'h2;
  localparam logic [1:0] EV_BLK_OFF  = 2'h3;

  localparam logic [1:0] COND_NORMAL  = 2'h0;
  localparam logic [1:0] COND_TRIP    = 2'h1;
  localparam logic [1:0] COND_BLOCKED = 2'h2;

  typedef enum logic [2:0] {
    ST_NORMAL  = 3'b001,
    ST_TRIP    = 3'b010,
    ST_BLOCKED = 3'b100
  } efb_cond_t;

endpackage : efb_pkg

// ---- hw/efb_rec_store.sv ----
// ring store of the most recent operation records
// assumes a synchronised active low reset and one write pulse per record
`timescale 1ns/100ps
`default_nettype none
module efb_rec_store #(
  parameter int DEPTH = efb_pkg::REC_DEPTH,
  parameter int W     = efb_pkg::REC_W
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [3:0]   rd_sel,
  output logic      [W-1:0] rd_data,
  output logic      [3:0]   count
);
  import efb_pkg::*;

  typedef struct packed {
    logic [3:0] ptr;
    logic [3:0] cnt;
  } efb_rs_state_t;

  efb_rs_state_t q;
  efb_rs_state_t d;
  logic [W-1:0]  mem [DEPTH];
  logic [3:0]    idx;

  localparam logic [3:0] LAST = 4'(DEPTH - 1);

  always_comb
  begin
    d = q;
    if (wr_en)
    begin
      // full store wraps onto the oldest slot
      d.ptr = (q.ptr == LAST) ? 4'h0 : q.ptr + 4'h1;
      if (q.cnt != 4'(DEPTH))
      begin
        d.cnt = q.cnt + 4'h1;
      end
    end
    // select 0 is the newest record
    if (rd_sel >= q.ptr)
    begin
      idx = 4'(DEPTH) + q.ptr - 4'h1 - rd_sel;
    end
    else
    begin
      idx = q.ptr - 4'h1 - rd_sel;
    end
    rd_data = (rd_sel < q.cnt) ? mem[idx] : '0;
    count   = q.cnt;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // memory holds no reset; unused slots read as zero via cnt
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[q.ptr] <= wr_data;
    end
  end

endmodule : efb_rec_store
`default_nettype wire

// ---- hw/efb_trip_block.sv ----
// blocking, trip, event and record logic of the residual differential stage
// assumes apb master on clock, pick-up and block arrive as async pins
//
// Operation
// - block input sampled once per processing cycle tick, used all cycle
// - block comes only from the dedicated blocking matrix input pin
// - pick-up with block inactive raises trip and runs operate timing
// - pick-up with block active raises blocked and processes nothing else
// - block during trip drops trip and runs release timing as pick-up loss
// - four events: trip on, trip off, block on, block off
// - per event config chooses whether it enters the event buffer
// - each buffered event carries a millisecond time stamp
// - trip and blocked counts kept, cleared by a command
// - twelve newest operation records kept
// - records captured only on asserting edges with present process data
// - record holds stamp, event, currents, maxima, residuals, group
// - condition is exactly one of normal, tripped, blocked
`timescale 1ns/100ps
`default_nettype none
module efb_trip_block #(
  parameter int CYC_CLKS = efb_pkg::CYCLE_CLKS,
  parameter int MS_CLK   = efb_pkg::MS_CLKS
) (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      block_in,
  input  wire logic                      residual_diff_stage_pickup,
  input  wire logic [efb_pkg::CUR_W-1:0] bias_current,
  input  wire logic [efb_pkg::CUR_W-1:0] diff_current,
  input  wire logic [efb_pkg::CUR_W-1:0] char_current,
  input  wire logic [efb_pkg::CUR_W-1:0] calculated_residual_current,
  input  wire logic [efb_pkg::CUR_W-1:0] measured_residual_current,
  input  wire logic [efb_pkg::GRP_W-1:0] setting_group,
  output logic                           trip,
  output logic                           blocked,
  output logic                           operate,
  output logic      [2:0]                condition,
  output logic                           ev_valid,
  output logic      [1:0]                ev_code,
  output logic      [31:0]               ev_stamp,
  output logic                           irq
);
  import efb_pkg::*;

  typedef struct packed {
    logic [2:0]       blk_s;
    logic [2:0]       pk_s;
    logic             blk_f;
    logic             pk_f;
    logic [15:0]      div;
    logic [15:0]      msdiv;
    logic [31:0]      stamp;
    efb_cond_t        cond;
    logic [15:0]      op_cnt;
    logic [15:0]      rel_cnt;
    logic             operate;
    logic             trip;
    logic             blocked;
    logic [15:0]      bmax;
    logic [15:0]      dmax;
    logic [15:0]      cmax;
    logic             en;
    logic [3:0]       evcfg;
    logic [15:0]      op_dly;
    logic [15:0]      rel_dly;
    logic [3:0]       ista;
    logic [3:0]       imask;
    logic             irq;
    logic [31:0]      tcnt;
    logic [31:0]      bcnt;
    logic [3:0]       rsel;
    logic [3:0]       evpend;
    logic [31:0]      evstamp;
    logic             ev_valid;
    logic [1:0]       ev_code;
    logic [31:0]      ev_stamp;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             rec_we;
    logic [REC_W-1:0] rec_d;
  } efb_state_t;

  efb_state_t       q;
  efb_state_t       d;
  logic [1:0]       rst_s;
  logic             rst_n;
  logic [REC_W-1:0] rec_rd;
  logic [3:0]       rec_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s <= 2'h0;
    end
    else
    begin
      rst_s <= {rst_s[0], 1'h1};
    end
  end
  assign rst_n = rst_s[1];

  ////////////////////////////////////////////////////////////////////////////
  efb_rec_store #(
    .DEPTH (REC_DEPTH),
    .W     (REC_W)
  ) efb_rec_store_inst (
    .clock   (clock),
    .rst_n   (rst_n),
    .wr_en   (q.rec_we),
    .wr_data (q.rec_d),
    .rd_sel  (q.rsel),
    .rd_data (rec_rd),
    .count   (rec_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic       tick;
  logic       blk;
  logic       pk;
  logic [3:0] ev;
  logic [3:0] wc;
  logic       acc;
  logic       hit;
  logic       wr;
  logic [31:0] rd;
  logic [15:0] bm;
  logic [15:0] dm;
  logic [15:0] cm;
  logic [1:0]  cc;

  always_comb
  begin
    d      = q;
    ev     = 4'h0;
    wc     = 4'h0;
    rd     = 32'h0000_0000;
    hit    = 1'h1;
    blk    = q.blk_f;
    pk     = q.pk_f & q.en;
    bm     = q.bmax;
    dm     = q.dmax;
    cm     = q.cmax;
    cc     = COND_NORMAL;
    d.rec_we   = 1'h0;
    d.ev_valid = 1'h0;

    // three-stage pin sync; value moves once stages 2 and 3 agree
    d.blk_s = {q.blk_s[1:0], block_in};
    d.pk_s  = {q.pk_s[1:0], residual_diff_stage_pickup};
    if (q.blk_s[1] == q.blk_s[2])
    begin
      d.blk_f = q.blk_s[2];
    end
    if (q.pk_s[1] == q.pk_s[2])
    begin
      d.pk_f = q.pk_s[2];
    end

    // millisecond time base for stamps
    if (q.msdiv == 16'(MS_CLK - 1))
    begin
      d.msdiv = 16'h0000;
      d.stamp = q.stamp + 32'h0000_0001;
    end
    else
    begin
      d.msdiv = q.msdiv + 16'h0001;
    end

    tick = (q.div == 16'(CYC_CLKS - 1));
    d.div = tick ? 16'h0000 : q.div + 16'h0001;

    if (tick)
    begin
      // maxima follow the pick-up episode
      if (pk)
      begin
        bm = (bias_current > q.bmax) ? bias_current : q.bmax;
        dm = (diff_current > q.dmax) ? diff_current : q.dmax;
        cm = (char_current > q.cmax) ? char_current : q.cmax;
      end
      else
      begin
        bm = 16'h0000;
        dm = 16'h0000;
        cm = 16'h0000;
      end
      d.bmax = bm;
      d.dmax = dm;
      d.cmax = cm;

      // release timing, operate time memory dies when it runs out
      if (q.cond != ST_TRIP && q.rel_cnt != 16'h0000)
      begin
        d.rel_cnt = q.rel_cnt - 16'h0001;
        if (q.rel_cnt == 16'h0001)
        begin
          d.op_cnt = 16'h0000;
        end
      end

      // blk holds the filtered pin value at this tick, the last clock of the cycle
      case (q.cond)
        ST_NORMAL:
        begin
          if (pk && !blk)
          begin
            d.cond    = ST_TRIP;
            d.rel_cnt = 16'h0000;
            ev[EV_TRIP_ON] = 1'h1;
          end
          else if (pk && blk)
          begin
            d.cond = ST_BLOCKED;
            ev[EV_BLK_ON] = 1'h1;
          end
        end
        ST_TRIP:
        begin
          if (blk || !pk)
          begin
            // block and pick-up loss share one release path
            d.cond    = (blk && pk) ? ST_BLOCKED : ST_NORMAL;
            d.rel_cnt = q.rel_dly;
            if (q.rel_dly == 16'h0000)
            begin
              d.op_cnt = 16'h0000;
            end
            ev[EV_TRIP_OFF] = 1'h1;
            ev[EV_BLK_ON]   = blk && pk;
          end
          else if (q.op_cnt != 16'hFFFF)
          begin
            d.op_cnt = q.op_cnt + 16'h0001;
          end
        end
        ST_BLOCKED:
        begin
          if (!blk || !pk)
          begin
            d.cond = ST_NORMAL;
            ev[EV_BLK_OFF] = 1'h1;
          end
        end
        default:
        begin
          d.cond = ST_NORMAL;
        end
      endcase

      // capture on asserting edges only
      if (ev[EV_TRIP_ON] || ev[EV_BLK_ON])
      begin
        d.rec_we = 1'h1;
        d.rec_d  = {q.stamp, ev[EV_TRIP_ON] ? EV_TRIP_ON : EV_BLK_ON,
                    setting_group, bias_current, diff_current,
                    char_current, bm, dm, cm,
                    calculated_residual_current,
                    measured_residual_current};
      end
      d.evpend  = q.evpend | (ev & q.evcfg);
      d.evstamp = q.stamp;
    end

    d.operate = (d.cond == ST_TRIP) && (d.op_cnt >= q.op_dly);

    // one buffered event per clock, lowest code first
    for (int i = 3; i >= 0; i--)
    begin
      if (q.evpend[i])
      begin
        d.ev_valid = 1'h1;
        d.ev_code  = 2'(i);
        d.ev_stamp = q.evstamp;
      end
    end
    if (d.ev_valid)
    begin
      d.evpend[d.ev_code] = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // apb: one wait state, write lands at the edge that sees pready high
    acc = psel && penable;
    wr  = acc && pwrite && q.pready;
    case (paddr)
      OFS_CTRL:     rd = {31'h0000_0000, q.en};
      OFS_EVT_CFG:  rd = {28'h000_0000, q.evcfg};
      OFS_OP_DLY:   rd = {16'h0000, q.op_dly};
      OFS_REL_DLY:  rd = {16'h0000, q.rel_dly};
      OFS_STATUS:   rd = {28'h000_0000, q.pk_f, q.operate,
                          (q.cond == ST_BLOCKED) ? COND_BLOCKED :
                          (q.cond == ST_TRIP) ? COND_TRIP : COND_NORMAL};
      OFS_IRQ_STAT: rd = {28'h000_0000, q.ista};
      OFS_IRQ_MASK: rd = {28'h000_0000, q.imask};
      OFS_TRIP_CNT: rd = q.tcnt;
      OFS_BLK_CNT:  rd = q.bcnt;
      OFS_TIME:     rd = q.stamp;
      OFS_REC_SEL:  rd = {28'h000_0000, q.rsel};
      OFS_REC_CNT:  rd = {28'h000_0000, rec_cnt};
      OFS_REC0:     rd = rec_rd[REC_W-1 -: 32];
      OFS_REC1:     rd = {27'h000_0000, rec_rd[132:128]};
      OFS_REC2:     rd = rec_rd[127:96];
      OFS_REC3:     rd = rec_rd[95:64];
      OFS_REC4:     rd = rec_rd[63:32];
      OFS_REC5:     rd = rec_rd[31:0];
      default:      hit = 1'h0;
    endcase
    d.pready  = acc && !q.pready;
    // error flag stands only beside its pready pulse
    d.pslverr = acc && !q.pready && !hit;
    if (acc && !q.pready)
    begin
      d.prdata = pwrite ? 32'h0000_0000 : rd;
    end

    if (wr)
    begin
      case (paddr)
        OFS_CTRL:     d.en = pwdata[CTRL_EN_BIT];
        OFS_EVT_CFG:  d.evcfg = pwdata[3:0];
        OFS_OP_DLY:   d.op_dly = pwdata[15:0];
        OFS_REL_DLY:  d.rel_dly = pwdata[15:0];
        OFS_IRQ_STAT: wc = pwdata[3:0];
        OFS_IRQ_MASK: d.imask = pwdata[3:0];
        OFS_TIME:     d.stamp = pwdata;
        OFS_REC_SEL:  d.rsel = pwdata[3:0];
        default:      d.rsel = q.rsel;
      endcase
    end

    // counts: clear command first, a same-cycle occurrence still counts
    if (wr && paddr == OFS_CTRL && pwdata[CTRL_CLR_BIT])
    begin
      d.tcnt = 32'h0000_0000;
      d.bcnt = 32'h0000_0000;
    end
    if (ev[EV_TRIP_ON])
    begin
      d.tcnt = d.tcnt + 32'h0000_0001;
    end
    if (ev[EV_BLK_ON])
    begin
      d.bcnt = d.bcnt + 32'h0000_0001;
    end

    // sticky status, a new event beats a write-one clear
    d.ista = (q.ista & ~wc) | ev;
    d.irq  = |(d.ista & d.imask);
    d.trip    = (d.cond == ST_TRIP);
    d.blocked = (d.cond == ST_BLOCKED);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q         <= '0;
      q.cond    <= ST_NORMAL;
      q.en      <= CTRL_EN_RST;
      q.evcfg   <= EVT_CFG_RST;
      q.op_dly  <= OP_DLY_RST;
      q.rel_dly <= REL_DLY_RST;
      q.imask   <= IRQ_MASK_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign trip      = q.trip;
  assign blocked   = q.blocked;
  assign operate   = q.operate;
  assign condition = q.cond;
  assign ev_valid  = q.ev_valid;
  assign ev_code   = q.ev_code;
  assign ev_stamp  = q.ev_stamp;
  assign irq       = q.irq;

endmodule : efb_trip_block
`default_nettype wire

// ---- tb/earth_fault_block_trip_events_test.sv ----
// self-checking bench of the trip/block stage over apb
// assumes 16-clock ticks and 4-clock milliseconds
`timescale 1ns/100ps
`default_nettype none
module earth_fault_block_trip_events_test;
  import efb_pkg::*;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ev_stamp, stamp;
  logic block_in, pickup, pick_req, blk_req, trip, blocked, operate;
  logic ev_valid, irq;
  logic [1:0] ev_code, ev_last;
  logic [2:0] condition, grp;
  logic [15:0] bias, diff, chr;
  int n_errors, num_checks, ev_n;
  efb_trip_block #(.CYC_CLKS(16), .MS_CLK(4)) efb_trip_block_inst (
    .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .block_in, .residual_diff_stage_pickup(pickup),
    .bias_current(bias), .diff_current(diff), .char_current(chr),
    .calculated_residual_current(diff), .measured_residual_current(bias),
    .setting_group(grp), .trip, .blocked, .operate, .condition, .ev_valid,
    .ev_code, .ev_stamp, .irq);
  efb_far_side efb_far_side_inst (.clock, .pick_req, .blk_req, .block_in,
    .pickup, .bias, .diff, .chr, .grp);
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
    if (ev_valid === 1'b1)
    begin
      ev_n++;
      ev_last = ev_code;
      stamp = ev_stamp;
    end
  ////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, e);
  endtask : rdc
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rdc("ctrl", OFS_CTRL, 32'h0000_0001);
    rdc("evt_cfg", OFS_EVT_CFG, 32'h0000_000F);
    rdc("op_dly", OFS_OP_DLY, 32'h0000_000A);
    rdc("rel_dly", OFS_REL_DLY, 32'h0000_0004);
    rdc("irq_mask", OFS_IRQ_MASK, 32'h0000_0000);
    rdc("unmapped", 8'hFC, 32'h0000_0000);
    chk("unmapped_err", er, 1'b1);
  endtask : t_regs
  task t_trip;
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, OFS_TIME, 32'h0000_1000);
    ev_n = 0;
    pick_req <= 1'b1;
    cyc(40);
    chk("trip", trip, 1'b1);
    chk("cond", condition, ST_TRIP);
    chk("ev_n", ev_n, 1);
    chk("ev_code", ev_last, EV_TRIP_ON);
    chk("stamp", stamp - 32'h0000_1000 < 32'h0000_0014, 1'b1);
    chk("irq", irq, 1'b1);
    rdc("trip_cnt", OFS_TRIP_CNT, 32'h0000_0001);
    rdc("rec_cnt", OFS_REC_CNT, 32'h0000_0001);
    rdc("rec1", OFS_REC1, 32'h0000_0002);
    apb(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
    cyc(2);
    chk("irq_clr", irq, 1'b0);
    cyc(180);
    chk("operate", operate, 1'b1);
  endtask : t_trip
  task t_blk_trip;
    ev_n = 0;
    blk_req <= 1'b1;
    cyc(40);
    chk("trip_drop", trip, 1'b0);
    chk("blocked", blocked, 1'b1);
    chk("cond_b", condition, ST_BLOCKED);
    chk("ev_n2", ev_n, 2);
    chk("ev_blk", ev_last, EV_BLK_ON);
    rdc("blk_cnt", OFS_BLK_CNT, 32'h0000_0001);
  endtask : t_blk_trip
  task t_blk_first;
    pick_req <= 1'b0;
    cyc(40);
    chk("cond_n", condition, ST_NORMAL);
    chk("ev_boff", ev_last, EV_BLK_OFF);
    pick_req <= 1'b1;
    cyc(40);
    chk("no_trip", trip, 1'b0);
    chk("blocked2", blocked, 1'b1);
    blk_req <= 1'b0;
    pick_req <= 1'b0;
    cyc(40);
  endtask : t_blk_first
  task t_cfg;
    apb(1'b1, OFS_EVT_CFG, 32'h0000_0002);
    ev_n = 0;
    pick_req <= 1'b1;
    cyc(40);
    chk("ev_muted", ev_n, 0);
    rdc("trip_cnt2", OFS_TRIP_CNT, 32'h0000_0002);
    pick_req <= 1'b0;
    cyc(40);
    chk("ev_off", ev_n, 1);
    chk("ev_toff", ev_last, EV_TRIP_OFF);
    apb(1'b1, OFS_EVT_CFG, 32'h0000_000F);
  endtask : t_cfg
  task t_clear;
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    rdc("trip_clr", OFS_TRIP_CNT, 32'h0000_0000);
    rdc("blk_clr", OFS_BLK_CNT, 32'h0000_0000);
  endtask : t_clear
  task t_ring;
    repeat (12)
    begin
      pick_req <= 1'b1;
      cyc(40);
      pick_req <= 1'b0;
      cyc(40);
    end
    rdc("rec_full", OFS_REC_CNT, 32'h0000_000C);
    apb(1'b1, OFS_REC_SEL, 32'h0000_000B);
    // off edges would put code 1 at select 10; the oldest slot holds code 0 either way
    rdc("rec_old", OFS_REC1, 32'h0000_0002);
  endtask : t_ring
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; pick_req = 1'b0; blk_req = 1'b0;
    n_errors = 0; num_checks = 0; ev_n = 0;
    cyc(20);
    rst_b <= 1'b1;
    cyc(3);
    t_regs;
    t_trip;
    t_blk_trip;
    t_blk_first;
    t_cfg;
    t_clear;
    t_ring;
    print_verdict;
  end
  initial
  begin
    #600000;
    n_errors++;
    print_verdict;
  end
endmodule : earth_fault_block_trip_events_test
`default_nettype wire

// ---- tb/efb_far_side.sv ----
// blocking matrix and measurement side feeding the stage
// assumes requests from the bench; currents change every clock
`timescale 1ns/100ps
`default_nettype none
module efb_far_side
  import efb_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             pick_req,
  input  wire logic             blk_req,
  output logic                  block_in,
  output logic                  pickup,
  output logic      [CUR_W-1:0] bias,
  output logic      [CUR_W-1:0] diff,
  output logic      [CUR_W-1:0] chr,
  output logic      [GRP_W-1:0] grp
);
  initial
  begin
    block_in = 1'b0;
    pickup   = 1'b0;
    bias     = 16'h0000;
  end
  // the bench first raises blk_req after the operate delay has run out and operate is up
  always @(posedge clock)
  begin
    block_in <= blk_req;
    pickup   <= pick_req;
    bias     <= bias + 16'h0001;
  end
  assign diff = ~bias;
  assign chr  = {bias[7:0], bias[15:8]};
  assign grp  = 3'h2;
endmodule : efb_far_side
`default_nettype wire

// ---- tb/efb_trip_block_properties.sv ----
// concurrent checks on the trip/block stage ports
// assumes binding into efb_trip_block, one clock domain
`timescale 1ns/100ps
`default_nettype none
module efb_trip_block_properties
  import efb_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       trip,
  input wire logic       blocked,
  input wire logic       operate,
  input wire logic [2:0] condition,
  input wire logic       ev_valid,
  input wire logic [1:0] ev_code,
  input wire logic       irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  a_cond_onehot: assert property ($onehot(condition))
    else $error("condition not one-hot");
  a_cond_match: assert property (trip == condition[1] &&
    blocked == condition[2]) else $error("condition disagrees");
  // decisions only at ticks, which are 16 clocks apart in simulation
  a_trip_hold: assert property ($changed(trip) |=> $stable(trip)[*8])
    else $error("trip moved between ticks");
  a_blk_hold: assert property ($changed(blocked) |=>
    $stable(blocked)[*8]) else $error("blocked moved between ticks");
  a_blk_no_trip: assert property (blocked |=> !trip)
    else $error("trip straight out of blocked");
  a_trip_on_ev: assert property (ev_valid && ev_code == EV_TRIP_ON |->
    $past(trip) && !$past(trip, 2)) else $error("trip on event misplaced");
  a_trip_off_ev: assert property (ev_valid && ev_code == EV_TRIP_OFF |->
    !$past(trip) && $past(trip, 2)) else $error("trip off misplaced");
  a_blk_on_ev: assert property (ev_valid && ev_code == EV_BLK_ON |->
    blocked) else $error("block on event without blocked");
  a_op_trip: assert property ($rose(operate) |-> trip)
    else $error("operate without trip");
  a_apb_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("apb answer late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  c_trip: cover property ($rose(trip));
  c_blk: cover property ($rose(blocked));
  c_blk_off: cover property (ev_valid && ev_code == EV_BLK_OFF);
  c_irq: cover property ($rose(irq));
endmodule : efb_trip_block_properties
bind efb_trip_block efb_trip_block_properties efb_trip_block_properties_inst
  (.clock, .rst_b, .psel, .penable, .pready, .pslverr, .trip, .blocked,
   .operate, .condition, .ev_valid, .ev_code, .irq);
`default_nettype wire
